// ---- logic/skip_xor_pkg.sv ----
// Package: constants and carriers for the test-skip and xor-literal executor.
// Assumes one instruction cycle per clk_sys_in edge at 20 MHz.
package skip_xor_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Encodings
    localparam logic [6:0]  OPC_TEST_SKIP   = 7'h33;   // Bits 15:9 of 0110_011a
    localparam logic [7:0]  OPC_XOR_LIT     = 8'h0a;   // Bits 15:8 of 0000_1010
    localparam logic [7:0]  INDEX_LIMIT     = 8'h5f;   // Literal-offset window top
    localparam logic [7:0]  ZERO_BYTE       = 8'h00;
    localparam logic [7:0]  W_RESET         = 8'h00;
    localparam logic [3:0]  BANK_RESET      = 4'h0;
    localparam logic [3:0]  ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0]  ACCESS_HI_BANK  = 4'hf;
    localparam logic [7:0]  ACCESS_SPLIT    = 8'h60;   // Access bank low/high split
    localparam logic [1:0]  SKIP_ONE_WORD   = 2'h1;
    localparam logic [1:0]  SKIP_TWO_WORD   = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic        valid;
        logic [15:0] word;
        logic        two_word;   // Opcode is first word of a 2-word instruction
    } fetch_t;

    typedef struct packed {
        logic        valid;
        logic [11:0] addr;
        logic        indexed;    // Address is an offset from the index pointer
    } data_req_t;

    typedef enum logic [1:0] {
        ST_EXEC,
        ST_IDLE
    } exec_state_t;

endpackage : skip_xor_pkg

// ---- logic/file_addr_resolve.sv ----
// File address resolver: direct, banked, access-bank or literal-offset form.
// Assumes bank select value is stable during the cycle.
`timescale 1ns/1ps
module file_addr_resolve
(
    input  wire logic [7:0]  file_in,
    input  wire logic        bank_sel_in,
    input  wire logic        ext_set_in,
    input  wire logic [3:0]  bank_in,
    output skip_xor_pkg::data_req_t req_out
);
    always_comb
    begin
        req_out.valid   = 1'b1;
        req_out.indexed = 1'b0;
        if (!bank_sel_in && ext_set_in && file_in <= skip_xor_pkg::INDEX_LIMIT)
        begin
            req_out.indexed = 1'b1;
            req_out.addr    = {4'h0, file_in};
        end
        else if (bank_sel_in)
        begin
            req_out.addr    = {bank_in, file_in};
        end
        else if (file_in < skip_xor_pkg::ACCESS_SPLIT)
        begin
            req_out.addr    = {skip_xor_pkg::ACCESS_LOW_BANK, file_in};
        end
        else
        begin
            req_out.addr    = {skip_xor_pkg::ACCESS_HI_BANK, file_in};
        end
    end
endmodule : file_addr_resolve

// ---- logic/test_file_skip_if_zero_exec.sv ----
// Executes test_file_skip_if_zero and xor_literal_into_working for the core.
// Assumes data read answers combinationally in the same instruction cycle and
// that the fetch unit flags two-word opcodes.
`timescale 1ns/1ps
module test_file_skip_if_zero_exec
(
    input  wire logic                    clk_sys_in,
    input  wire logic                    rst_in,
    input  wire skip_xor_pkg::fetch_t    fetch_in,
    input  wire logic                    ext_set_in,
    input  wire logic [3:0]              bank_wr_in,
    input  wire logic                    bank_we_in,
    input  wire logic [7:0]              rd_data_in,
    output skip_xor_pkg::data_req_t      rd_req_out,
    output logic [7:0]                   working_out,
    output logic [3:0]                   bank_select_register_out,
    output logic                         skip_taken_out,
    output logic                         idle_cycle_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    logic                       is_test;
    logic                       is_xor;
    skip_xor_pkg::data_req_t    req_c;
    skip_xor_pkg::exec_state_t  state_q, state_d;
    logic [1:0]                 idle_q, idle_d;
    logic [7:0]                 w_q, w_d;
    logic [3:0]                 bank_q, bank_d;
    logic                       skip_q, skip_d;
    logic                       idle_out_q, idle_out_d;
    skip_xor_pkg::data_req_t    req_q, req_d;

    assign is_test = fetch_in.valid && fetch_in.word[15:9] == skip_xor_pkg::OPC_TEST_SKIP;
    assign is_xor  = fetch_in.valid && fetch_in.word[15:8] == skip_xor_pkg::OPC_XOR_LIT;

    file_addr_resolve u_resolve
    (
        .file_in     (fetch_in.word[7:0]),
        .bank_sel_in (fetch_in.word[8]),
        .ext_set_in  (ext_set_in),
        .bank_in     (bank_q),
        .req_out     (req_c)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        state_d    = state_q;
        idle_d     = idle_q;
        w_d        = w_q;
        bank_d     = bank_q;
        skip_d     = 1'b0;
        idle_out_d = 1'b0;
        req_d      = '0;
        unique case (state_q)
            skip_xor_pkg::ST_EXEC:
            begin
                if (bank_we_in)
                begin
                    bank_d = bank_wr_in;
                end
                if (is_test)
                begin
                    req_d = req_c;
                    if (rd_data_in == skip_xor_pkg::ZERO_BYTE)
                    begin
                        skip_d  = 1'b1;
                        state_d = skip_xor_pkg::ST_IDLE;
                        // Fetch flags the word after this one
                        idle_d  = skip_xor_pkg::SKIP_ONE_WORD;
                    end
                end
                else if (is_xor)
                begin
                    w_d = w_q ^ fetch_in.word[7:0];
                end
            end
            skip_xor_pkg::ST_IDLE:
            begin
                // Discarded word: no state written, only the fetch two_word flag is used
                idle_out_d = 1'b1;
                if (fetch_in.two_word && idle_q == skip_xor_pkg::SKIP_ONE_WORD)
                begin
                    idle_d = skip_xor_pkg::SKIP_TWO_WORD;
                end
                else
                begin
                    idle_d  = 2'h0;
                    state_d = skip_xor_pkg::ST_EXEC;
                end
            end
            default:
            begin
                state_d = skip_xor_pkg::ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            state_q    <= skip_xor_pkg::ST_EXEC;
            idle_q     <= 2'h0;
            w_q        <= skip_xor_pkg::W_RESET;
            bank_q     <= skip_xor_pkg::BANK_RESET;
            skip_q     <= 1'b0;
            idle_out_q <= 1'b0;
            req_q      <= '0;
        end
        else
        begin
            state_q    <= state_d;
            idle_q     <= idle_d;
            w_q        <= w_d;
            bank_q     <= bank_d;
            skip_q     <= skip_d;
            idle_out_q <= idle_out_d;
            req_q      <= req_d;
        end
    end

    assign working_out              = w_q;
    assign bank_select_register_out = bank_q;
    assign skip_taken_out           = skip_q;
    assign idle_cycle_out           = idle_out_q;
    assign rd_req_out               = req_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertion helper: length of each run of idle cycles
    // Drops back to 0 after reaching 3, so an overlong run reads 3 for one cycle only
    logic [1:0]                 idle_run_q, idle_run_d;

    always_comb
    begin
        idle_run_d = 2'h0;
        if (idle_cycle_out && idle_run_q != 2'h3)
        begin
            idle_run_d = idle_run_q + 2'h1;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            idle_run_q <= 2'h0;
        end
        else
        begin
            idle_run_q <= idle_run_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_xor_result: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_q == skip_xor_pkg::ST_EXEC && is_xor)
        |=> working_out == ($past(w_q) ^ $past(fetch_in.word[7:0])))
        else $error("xor result wrong");
    a_xor_other_w: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_q == skip_xor_pkg::ST_EXEC && !is_xor)
        |=> $stable(working_out))
        else $error("working register changed without xor");
    a_zero_skips: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_q == skip_xor_pkg::ST_EXEC && is_test && rd_data_in == 8'h00)
        |=> skip_taken_out ##1 idle_cycle_out)
        else $error("zero did not skip");
    a_skip_one_pulse: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        skip_taken_out
        |=> !skip_taken_out)
        else $error("skip flag stood too long");
    a_test_drives_req: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_q == skip_xor_pkg::ST_EXEC && is_test)
        |=> rd_req_out.valid)
        else $error("test issued no file read");
    a_nonzero_runs: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_q == skip_xor_pkg::ST_EXEC && is_test && rd_data_in != 8'h00)
        |=> !skip_taken_out ##1 !idle_cycle_out)
        else $error("nonzero test skipped");
    a_idle_keeps_w: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_q == skip_xor_pkg::ST_IDLE)
        |=> $stable(working_out) && $stable(bank_select_register_out))
        else $error("idle cycle changed state");
    a_idle_no_req: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_q == skip_xor_pkg::ST_IDLE)
        |=> !rd_req_out.valid && !skip_taken_out)
        else $error("idle cycle issued work");
    a_idle_flagged: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_q == skip_xor_pkg::ST_IDLE)
        |=> idle_cycle_out)
        else $error("idle cycle not flagged");
    a_two_word_len: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_q == skip_xor_pkg::ST_IDLE && idle_q == 2'h1 && fetch_in.two_word)
        |=> state_q == skip_xor_pkg::ST_IDLE ##1 state_q == skip_xor_pkg::ST_EXEC)
        else $error("two-word skip length wrong");
    a_one_word_len: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_q == skip_xor_pkg::ST_IDLE && idle_q == skip_xor_pkg::SKIP_ONE_WORD && !fetch_in.two_word)
        |=> state_q == skip_xor_pkg::ST_EXEC)
        else $error("one-word skip length wrong");
    a_second_idle_end: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_q == skip_xor_pkg::ST_IDLE && idle_q == skip_xor_pkg::SKIP_TWO_WORD)
        |=> state_q == skip_xor_pkg::ST_EXEC)
        else $error("second idle did not end skip");
    a_idle_run_max: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        idle_run_q != 2'h3)
        else $error("more than two idle cycles in a row");
    a_index_mode: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_q == skip_xor_pkg::ST_EXEC && is_test && ext_set_in && !fetch_in.word[8]
            && fetch_in.word[7:0] <= 8'h5f)
        |=> rd_req_out.indexed)
        else $error("indexed mode missed");
    a_index_addr: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_q == skip_xor_pkg::ST_EXEC && is_test && ext_set_in && !fetch_in.word[8]
            && fetch_in.word[7:0] <= skip_xor_pkg::INDEX_LIMIT)
        |=> rd_req_out.addr == {4'h0, $past(fetch_in.word[7:0])})
        else $error("indexed offset wrong");
    a_bank_select: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_q == skip_xor_pkg::ST_EXEC && is_test && fetch_in.word[8])
        |=> rd_req_out.addr[11:8] == $past(bank_q) && !rd_req_out.indexed)
        else $error("banked address wrong");
    a_access_bank: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_q == skip_xor_pkg::ST_EXEC && is_test && !fetch_in.word[8] && !ext_set_in
            && fetch_in.word[7:0] < 8'h60)
        |=> rd_req_out.addr[11:8] == 4'h0)
        else $error("access bank address wrong");
    a_access_high: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state_q == skip_xor_pkg::ST_EXEC && is_test && !fetch_in.word[8] && !ext_set_in
            && fetch_in.word[7:0] >= skip_xor_pkg::ACCESS_SPLIT)
        |=> rd_req_out.addr[11:8] == skip_xor_pkg::ACCESS_HI_BANK)
        else $error("upper access bank address wrong");

endmodule : test_file_skip_if_zero_exec

// ---- tb/tb_test_file_skip_if_zero_exec.sv ----
// Testbench for the test-skip and xor-literal executor.
// Assumes the package is compiled first; assertions live in the design files.
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_test_file_skip_if_zero_exec;
    ////////////////////////////////////////////////////////////////////////////
    logic                    clk_sys_in = 1'b0;
    logic                    rst_in     = 1'b1;
    skip_xor_pkg::fetch_t    fetch_in   = '0;
    logic                    ext_set_in = 1'b0;
    logic [3:0]              bank_wr_in = 4'h0;
    logic                    bank_we_in = 1'b0;
    logic [7:0]              rd_data_in = 8'h00;
    skip_xor_pkg::data_req_t rd_req_out;
    logic [7:0]              working_out;
    logic [3:0]              bank_select_register_out;
    logic                    skip_taken_out;
    logic                    idle_cycle_out;
    int                      n_mismatch  = 0;
    int                      checks_done = 0;
    always #25 clk_sys_in = ~clk_sys_in;
    test_file_skip_if_zero_exec dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .fetch_in(fetch_in),
        .ext_set_in(ext_set_in), .bank_wr_in(bank_wr_in), .bank_we_in(bank_we_in), .rd_data_in(rd_data_in),
        .rd_req_out(rd_req_out), .working_out(working_out), .bank_select_register_out(bank_select_register_out),
        .skip_taken_out(skip_taken_out), .idle_cycle_out(idle_cycle_out));
    ////////////////////////////////////////////////////////////////////////////
    // One instruction per edge; outputs checked after an edge show the previous slot
    task automatic cyc(input logic vld, input logic [15:0] w, input logic tw, input logic [7:0] rd);
        @(posedge clk_sys_in);
        fetch_in   <= '{valid: vld, word: w, two_word: tw};
        rd_data_in <= rd;
        bank_we_in <= 1'b0;
        #1;
    endtask : cyc
    function automatic logic [15:0] tst(input logic a, input logic [7:0] f);
        return {skip_xor_pkg::OPC_TEST_SKIP, a, f};
    endfunction : tst
    function automatic logic [15:0] xl(input logic [7:0] k);
        return {skip_xor_pkg::OPC_XOR_LIT, k};
    endfunction : xl
    task automatic xor_case();
        cyc(1'b1, xl(8'hb5), 1'b0, 8'h00);
        cyc(1'b1, xl(8'haf), 1'b0, 8'h00);
        `CHK(working_out, 8'hb5)
        cyc(1'b0, 16'h0000, 1'b0, 8'h00);
        `CHK(working_out, 8'h1a)
        $display("test xor_case done");
    endtask : xor_case
    // Nonzero byte: the following xor must still execute
    task automatic no_skip_case();
        cyc(1'b1, tst(1'b0, 8'h20), 1'b0, 8'h01);
        cyc(1'b1, xl(8'h0f), 1'b0, 8'h00);
        `CHK(skip_taken_out, 1'b0)
        cyc(1'b0, 16'h0000, 1'b0, 8'h00);
        `CHK(idle_cycle_out, 1'b0)
        `CHK(working_out, 8'h15)
        $display("test no_skip_case done");
    endtask : no_skip_case
    // Zero byte: discarded words are xors, so a leak shows in working_out
    // One-word skip: the word after the discarded one executes again
    task automatic skip_case(input logic tw, input logic [7:0] w_exp);
        cyc(1'b1, tst(1'b0, 8'h21), 1'b0, 8'h00);
        // Bank write lands on the idle cycle and must be ignored
        @(posedge clk_sys_in);
        fetch_in   <= '{valid: 1'b1, word: xl(8'hff), two_word: tw};
        bank_wr_in <= 4'h9;
        bank_we_in <= 1'b1;
        #1;
        `CHK(skip_taken_out, 1'b1)
        cyc(1'b1, xl(8'hf0), 1'b0, 8'h00);
        `CHK(idle_cycle_out, 1'b1)
        `CHK(skip_taken_out, 1'b0)
        cyc(1'b0, 16'h0000, 1'b0, 8'h00);
        `CHK(idle_cycle_out, tw)
        cyc(1'b0, 16'h0000, 1'b0, 8'h00);
        `CHK(idle_cycle_out, 1'b0)
        `CHK(working_out, w_exp)
        `CHK(bank_select_register_out, 4'h0)
        $display("test skip_case done");
    endtask : skip_case
    task automatic addr_case(input logic a, input logic ext, input logic [7:0] f,
                             input logic [11:0] ea, input logic ei);
        skip_xor_pkg::data_req_t exp;
        exp = '{valid: 1'b1, addr: ea, indexed: ei};
        @(posedge clk_sys_in);
        ext_set_in <= ext;
        cyc(1'b1, tst(a, f), 1'b0, 8'h01);
        cyc(1'b0, 16'h0000, 1'b0, 8'h00);
        `CHK(rd_req_out, exp)
        $display("test addr_case done");
    endtask : addr_case
    task automatic bank_case();
        @(posedge clk_sys_in);
        bank_wr_in <= 4'h5;
        bank_we_in <= 1'b1;
        cyc(1'b0, 16'h0000, 1'b0, 8'h00);
        cyc(1'b0, 16'h0000, 1'b0, 8'h00);
        `CHK(bank_select_register_out, 4'h5)
        addr_case(1'b1, 1'b1, 8'h20, 12'h520, 1'b0);
        addr_case(1'b0, 1'b0, 8'h10, 12'h010, 1'b0);
        addr_case(1'b0, 1'b0, 8'h80, 12'hf80, 1'b0);
        addr_case(1'b0, 1'b1, 8'h5f, 12'h05f, 1'b1);
        addr_case(1'b0, 1'b1, 8'h60, 12'hf60, 1'b0);
    endtask : bank_case
    // Outputs at reset; after a mid-run reset an instruction must run again
    task automatic reset_case(input logic mid);
        if (mid)
        begin
            @(posedge clk_sys_in);
            rst_in <= 1'b1;
            repeat (2) @(posedge clk_sys_in);
            rst_in <= 1'b0;
            #1;
        end
        `CHK(working_out, 8'h00)
        `CHK(bank_select_register_out, 4'h0)
        `CHK(skip_taken_out, 1'b0)
        `CHK(idle_cycle_out, 1'b0)
        `CHK(rd_req_out, 14'h0000)
        if (mid)
        begin
            cyc(1'b1, xl(8'h3c), 1'b0, 8'h00);
            cyc(1'b0, 16'h0000, 1'b0, 8'h00);
            `CHK(working_out, 8'h3c)
        end
        $display("test reset_case done");
    endtask : reset_case
    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude
    initial
    begin
        repeat (4) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        #1;
        reset_case(1'b0);
        xor_case();
        no_skip_case();
        skip_case(1'b0, 8'he5);
        skip_case(1'b1, 8'he5);
        bank_case();
        reset_case(1'b1);
        conclude();
    end
    // Whole run is under 100 cycles; this is a generous ceiling
    initial
    begin
        repeat (2000) @(posedge clk_sys_in);
        n_mismatch++;
        conclude();
    end
endmodule : tb_test_file_skip_if_zero_exec
